/* dv/paired_timer_32bit_properties.sv */
// checker: bus handshake and event properties of the paired timer
`timescale 1ns/10ps
`default_nettype none
module paired_timer_32bit_properties
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// timer side
	input wire paired_timer_pkg::timer_in_s evenPins,
	input wire paired_timer_pkg::timer_in_s oddPins,
	input wire logic idle,
	input wire paired_timer_pkg::timer_ev_s events,
	input wire logic irq
);
	import paired_timer_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	property p_readyPulse; pready |=> !pready; endproperty
	a_readyPulse: assert property (p_readyPulse) else $error("pready held too long");
	property p_readyAfterAccess; psel && penable && !pready |=> pready; endproperty
	a_readyAfterAccess: assert property (p_readyAfterAccess) else $error("no answer one cycle into access");
	property p_readyCause; pready |-> $past(psel) && $past(penable); endproperty
	a_readyCause: assert property (p_readyCause) else $error("pready without access phase");
	property p_errWithReady; pslverr |-> pready; endproperty
	a_errWithReady: assert property (p_errWithReady) else $error("pslverr outside answer cycle");
	property p_dataIdle; !pready |-> prdata == 32'h0; endproperty
	a_dataIdle: assert property (p_dataIdle) else $error("read data outside answer cycle");
	property p_badStrobe; pready && $past(pwrite) && ($past(pstrb) & 4'h3) != 4'h3 |-> pslverr; endproperty
	a_badStrobe: assert property (p_badStrobe) else $error("short strobe write not refused");
	property p_unmapped; pready && !$past(pwrite) && $past(paddr) > 12'h024 |-> pslverr && prdata == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	property p_adcFollowsOdd; events.adcTrigger == events.oddMatch; endproperty
	a_adcFollowsOdd: assert property (p_adcFollowsOdd) else $error("converter trigger off odd match");
	property p_evenCtrlZeros;
		pready && !$past(pwrite) && $past(paddr) == OFF_EVEN_CTRL |-> (prdata & ~{16'h0, EVEN_CTRL_MASK}) == 32'h0;
	endproperty
	a_evenCtrlZeros: assert property (p_evenCtrlZeros) else $error("even control unused bits read set");
	property p_oddCtrlZeros;
		pready && !$past(pwrite) && $past(paddr) == OFF_ODD_CTRL |-> (prdata & ~{16'h0, ODD_CTRL_MASK}) == 32'h0;
	endproperty
	a_oddCtrlZeros: assert property (p_oddCtrlZeros) else $error("odd control unused bits read set");
	// main scenarios seen
	c_oddMatch: cover property (events.oddMatch);
	c_slvErr: cover property (pslverr);
	c_irq: cover property (irq);
endmodule : paired_timer_32bit_properties
bind paired_timer_32bit paired_timer_32bit_properties paired_timer_32bit_properties_i (.clk, .rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .evenPins, .oddPins, .idle, .events, .irq);
`default_nettype wire

/* dv/tb_paired_timer_32bit.sv */
// testbench: register access and timer runs of the paired timer
`timescale 1ns/10ps
`default_nettype none
module tb_paired_timer_32bit;
	import paired_timer_pkg::*;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	timer_in_s evenPins = 2'h0;
	timer_in_s oddPins = 2'h0;
	logic idle = 1'b0;
	timer_ev_s events;
	logic irq;
	logic [31:0] rd;
	logic er;
	int mismatches = 0;
	int samples_checked = 0;
	int n;
	int ratio[4] = '{1, 8, 64, 256};
	// 20 MHz clock
	always #25 clk = ~clk;
	paired_timer_32bit paired_timer_32bit_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .evenPins, .oddPins, .idle, .events, .irq);
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic check_value(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_value
	// one apb transfer, held until pready is sampled high
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check_value({31'h0, pready}, 32'h1);
	endtask : bus
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hf);
		check_value(rd, exp);
	endtask : rdc
	// wait for a match pulse, n gets the cycles waited
	task automatic wait_match(input logic odd, input int limit);
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end while ((odd ? events.oddMatch : events.evenMatch) !== 1'b1 && n < limit);
		check_value({31'h0, n < limit}, 32'h1);
		// converter trigger rides on odd or pair matches only
		if (odd)
			check_value({31'h0, events.adcTrigger}, 32'h1);
		else
			check_value({31'h0, events.adcTrigger}, 32'h0);
	endtask : wait_match
	// low count word moving or frozen over ten cycles
	task automatic run_check(input logic running);
		logic [31:0] a;
		bus(1'b0, OFF_CNT_LOW, 32'h0, 4'hf);
		a = rd;
		repeat (10) @(posedge clk);
		bus(1'b0, OFF_CNT_LOW, 32'h0, 4'hf);
		check_value({31'h0, rd !== a}, {31'h0, running});
	endtask : run_check
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	// watchdog against a hang
	initial
	begin
		repeat (40000) @(posedge clk);
		mismatches++;
		stop_test();
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rdc(OFF_EVEN_CTRL, 32'h0);
		rdc(OFF_PER_LOW, 32'hffff);
		wr(OFF_EVEN_CTRL, 32'h7fff);
		rdc(OFF_EVEN_CTRL, 32'h207a);
		wr(OFF_ODD_CTRL, 32'h7fff);
		rdc(OFF_ODD_CTRL, 32'h2072);
		wr(OFF_EVEN_CTRL, 32'h0);
		wr(OFF_ODD_CTRL, 32'h0);
		bus(1'b0, 12'h028, 32'h0, 4'hf);
		check_value({31'h0, er}, 32'h1);
		bus(1'b1, OFF_PER_LOW, 32'h1234, 4'h1);
		check_value({31'h0, er}, 32'h1);
		rdc(OFF_PER_LOW, 32'hffff);
		// match spacing is (period + 1) times the ratio
		wr(OFF_PER_LOW, 32'h3);
		for (int c = 0; c < 4; c++)
		begin
			wr(OFF_EVEN_CTRL, 32'h0);
			wr(OFF_CNT_LOW, 32'h0);
			wr(OFF_EVEN_CTRL, 32'h8000 | (c << 4));
			wait_match(1'b0, 3000);
			wait_match(1'b0, 3000);
			check_value(n, 4 * ratio[c]);
		end
		wr(OFF_EVEN_CTRL, 32'h0);
		check_value({31'h0, irq}, 32'h0);
		wr(OFF_IRQ_ENABLE, 32'h1);
		repeat (2) @(posedge clk);
		check_value({31'h0, irq}, 32'h1);
		rdc(OFF_IRQ_STATUS, 32'h1);
		wr(OFF_IRQ_CLEAR, 32'h1);
		repeat (2) @(posedge clk);
		check_value({31'h0, irq}, 32'h0);
		// idle and gating
		wr(OFF_PER_LOW, 32'hffff);
		idle <= 1'b1;
		wr(OFF_EVEN_CTRL, 32'ha000);
		run_check(1'b0);
		wr(OFF_EVEN_CTRL, 32'h8000);
		run_check(1'b1);
		idle <= 1'b0;
		wr(OFF_EVEN_CTRL, 32'h8040);
		run_check(1'b0);
		evenPins.gate <= 1'b1;
		run_check(1'b1);
		evenPins.gate <= 1'b0;
		// external clock edges, gate ignored
		wr(OFF_EVEN_CTRL, 32'h0);
		wr(OFF_CNT_LOW, 32'h0);
		wr(OFF_EVEN_CTRL, 32'h8042);
		repeat (5)
		begin
			repeat (3) @(posedge clk);
			evenPins.extClock <= 1'b1;
			repeat (3) @(posedge clk);
			evenPins.extClock <= 1'b0;
		end
		repeat (4) @(posedge clk);
		rdc(OFF_CNT_LOW, 32'h5);
		// chained pair, odd controls set slow but ignored
		wr(OFF_EVEN_CTRL, 32'h0008);
		wr(OFF_ODD_CTRL, 32'h8030);
		wr(OFF_PER_LOW, 32'h2);
		wr(OFF_PER_HIGH, 32'h1);
		wr(OFF_CNT_LOW, 32'hfffe);
		wr(OFF_CNT_HIGH, 32'h0);
		wr(OFF_IRQ_ENABLE, 32'h3);
		wr(OFF_EVEN_CTRL, 32'h8008);
		wait_match(1'b1, 20);
		rdc(OFF_IRQ_STATUS, 32'h2);
		check_value({31'h0, irq}, 32'h1);
		wr(OFF_EVEN_CTRL, 32'h0008);
		wr(OFF_PER_LOW, 32'hffff);
		wr(OFF_PER_HIGH, 32'hffff);
		wr(OFF_CNT_LOW, 32'hffff);
		wr(OFF_CNT_HIGH, 32'h0);
		wr(OFF_EVEN_CTRL, 32'h8008);
		wr(OFF_EVEN_CTRL, 32'h0008);
		rdc(OFF_CNT_HIGH, 32'h1);
		// odd timer alone
		wr(OFF_EVEN_CTRL, 32'h0);
		wr(OFF_IRQ_CLEAR, 32'h3);
		wr(OFF_PER_HIGH, 32'h1);
		wr(OFF_CNT_HIGH, 32'h0);
		wr(OFF_ODD_CTRL, 32'h8000);
		wait_match(1'b1, 20);
		rdc(OFF_IRQ_STATUS, 32'h2);
		stop_test();
	end
endmodule : tb_paired_timer_32bit
`default_nettype wire

/* src/paired_timer_32bit.sv */
// paired 16/32-bit timer with APB register access
`timescale 1ns/10ps
`default_nettype none

module paired_timer_32bit
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// timer pins: even and odd external clock and gate
	input wire paired_timer_pkg::timer_in_s evenPins,
	input wire paired_timer_pkg::timer_in_s oddPins,
	// device idle state
	input wire logic idle,
	// events
	output paired_timer_pkg::timer_ev_s events,
	output logic irq
);
	import paired_timer_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [15:0] evenCtrl;
		logic [15:0] oddCtrl;
		logic [15:0] periodLow;
		logic [15:0] periodHigh;
		logic [1:0] irqStatus;
		logic [1:0] irqEnable;
		logic [31:0] rdata;
		logic ready;
		logic slvErr;
		timer_ev_s ev;
		logic irq;
	} state_s;

	state_s q;
	state_s next_q;

	// bus decode
	logic access;
	logic wrEn;
	logic lowLanes;

	// decoded controls and datapath
	ctrl_s evenC;
	ctrl_s oddC;
	ctrl_s oddEff;
	logic pair;
	logic evenCtrlWr;
	logic oddCtrlWr;
	logic evenTick;
	logic oddTick;
	logic [15:0] countLow;
	logic [15:0] countHigh;
	logic lowAtPer;
	logic highAtPer;
	logic lowInc;
	logic highInc;
	logic lowClear;
	logic highClear;
	logic lowLoad;
	logic highLoad;
	logic evenMatch;
	logic oddMatch;

	// ---------------------------------------------------------------
	// bus access and control decode
	// ---------------------------------------------------------------
	assign access = psel & penable & ~q.ready;
	assign wrEn = access & pwrite;
	assign lowLanes = (pstrb[1:0] == 2'h3);
	assign evenC = decode_ctrl(q.evenCtrl);
	assign oddC = decode_ctrl(q.oddCtrl);
	assign pair = evenC.pairMode;
	assign evenCtrlWr = wrEn & lowLanes & (paddr == OFF_EVEN_CTRL) & evenC.on;
	assign oddCtrlWr = wrEn & lowLanes & (paddr == OFF_ODD_CTRL) & oddC.on;

	// odd timer is governed by even controls while paired
	always_comb
	begin
		oddEff = oddC;
		oddEff.pairMode = 1'b0;
		if (pair)
			oddEff = '0;
	end

	// ---------------------------------------------------------------
	// tick generators
	// ---------------------------------------------------------------
	timer_tick_gen evenTickGen
	(
		.clk(clk),
		.rst(rst),
		.ctrl(evenC),
		.ctrlWrite(evenCtrlWr),
		.idle(idle),
		.pins(evenPins),
		.tick(evenTick)
	);

	timer_tick_gen oddTickGen
	(
		.clk(clk),
		.rst(rst),
		.ctrl(oddEff),
		.ctrlWrite(oddCtrlWr),
		.idle(idle),
		.pins(oddPins),
		.tick(oddTick)
	);

	// ---------------------------------------------------------------
	// count words and match logic
	// ---------------------------------------------------------------
	// split: each word counts its own ticks; paired: carry from low word
	always_comb
	begin
		evenMatch = 1'b0;
		oddMatch = 1'b0;
		lowInc = 1'b0;
		highInc = 1'b0;
		lowClear = 1'b0;
		highClear = 1'b0;
		if (pair)
		begin
			// 32-bit compare of odd:even period against odd:even count
			oddMatch = evenTick & lowAtPer & highAtPer;
			lowInc = evenTick;
			highInc = evenTick & (countLow == 16'hffff);
			lowClear = oddMatch;
			highClear = oddMatch;
		end
		else
		begin
			evenMatch = evenTick & lowAtPer;
			oddMatch = oddTick & highAtPer;
			lowInc = evenTick;
			highInc = oddTick;
			lowClear = evenMatch;
			highClear = oddMatch;
		end
	end

	assign lowLoad = wrEn & lowLanes & (paddr == OFF_CNT_LOW);
	assign highLoad = wrEn & lowLanes & (paddr == OFF_CNT_HIGH);

	timer_count_word lowWord
	(
		.clk(clk),
		.rst(rst),
		.inc(lowInc),
		.clear(lowClear),
		.load(lowLoad),
		.loadValue(pwdata[15:0]),
		.period(q.periodLow),
		.count(countLow),
		.atPeriod(lowAtPer)
	);

	timer_count_word highWord
	(
		.clk(clk),
		.rst(rst),
		.inc(highInc),
		.clear(highClear),
		.load(highLoad),
		.loadValue(pwdata[15:0]),
		.period(q.periodHigh),
		.count(countHigh),
		.atPeriod(highAtPer)
	);

	// ---------------------------------------------------------------
	// registers, interrupts and bus answer
	// ---------------------------------------------------------------
	always_comb
	begin
		next_q = q;
		next_q.ready = access;
		next_q.slvErr = 1'b0;
		next_q.ev.evenMatch = evenMatch;
		next_q.ev.oddMatch = oddMatch;
		next_q.ev.adcTrigger = oddMatch;
		// register writes, only whole low half-word
		if (wrEn && lowLanes)
		begin
			case (paddr)
				OFF_EVEN_CTRL: next_q.evenCtrl = pwdata[15:0] & EVEN_CTRL_MASK;
				OFF_ODD_CTRL: next_q.oddCtrl = pwdata[15:0] & ODD_CTRL_MASK;
				OFF_PER_LOW: next_q.periodLow = pwdata[15:0];
				OFF_PER_HIGH: next_q.periodHigh = pwdata[15:0];
				OFF_IRQ_ENABLE: next_q.irqEnable = pwdata[1:0];
				OFF_IRQ_CLEAR: next_q.irqStatus = q.irqStatus & ~pwdata[1:0];
				OFF_CNT_LOW, OFF_CNT_HIGH, OFF_IRQ_STATUS, OFF_IDLE: ;
				default: next_q.slvErr = 1'b1;
			endcase
		end
		else if (wrEn)
			next_q.slvErr = 1'b1;
		// hardware set wins over software clear
		if (evenMatch)
			next_q.irqStatus[IRQ_EVEN] = 1'b1;
		if (oddMatch)
			next_q.irqStatus[IRQ_ODD] = 1'b1;
		next_q.irq = |(next_q.irqStatus & next_q.irqEnable);
		// read data
		next_q.rdata = 32'h00000000;
		if (access && !pwrite)
		begin
			case (paddr)
				OFF_EVEN_CTRL: next_q.rdata = {16'h0000, q.evenCtrl};
				OFF_ODD_CTRL: next_q.rdata = {16'h0000, q.oddCtrl};
				OFF_CNT_LOW: next_q.rdata = {16'h0000, countLow};
				OFF_CNT_HIGH: next_q.rdata = {16'h0000, countHigh};
				OFF_PER_LOW: next_q.rdata = {16'h0000, q.periodLow};
				OFF_PER_HIGH: next_q.rdata = {16'h0000, q.periodHigh};
				OFF_IRQ_STATUS: next_q.rdata = {30'h0, q.irqStatus};
				OFF_IRQ_ENABLE: next_q.rdata = {30'h0, q.irqEnable};
				OFF_IRQ_CLEAR: next_q.rdata = 32'h00000000;
				OFF_IDLE: next_q.rdata = {31'h0, idle};
				default: next_q.slvErr = 1'b1;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q <= '0;
			q.evenCtrl <= CTRL_RESET;
			q.oddCtrl <= CTRL_RESET;
			q.periodLow <= PERIOD_RESET;
			q.periodHigh <= PERIOD_RESET;
		end
		else
			q <= next_q;
	end

	// outputs straight from flip-flops
	assign prdata = q.rdata;
	assign pready = q.ready;
	assign pslverr = q.slvErr;
	assign events = q.ev;
	assign irq = q.irq;

endmodule : paired_timer_32bit
`default_nettype wire

/* src/paired_timer_pkg.sv */
// package: register map, control field layout, carriers for the paired timer
package paired_timer_pkg;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [11:0] OFF_EVEN_CTRL = 12'h000;
	localparam logic [11:0] OFF_ODD_CTRL = 12'h004;
	localparam logic [11:0] OFF_CNT_LOW = 12'h008;
	localparam logic [11:0] OFF_CNT_HIGH = 12'h00c;
	localparam logic [11:0] OFF_PER_LOW = 12'h010;
	localparam logic [11:0] OFF_PER_HIGH = 12'h014;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h018;
	localparam logic [11:0] OFF_IRQ_ENABLE = 12'h01c;
	localparam logic [11:0] OFF_IRQ_CLEAR = 12'h020;
	localparam logic [11:0] OFF_IDLE = 12'h024;

	// ---------------------------------------------------------------
	// control register fields
	// ---------------------------------------------------------------
	localparam int BIT_TIMER_ON = 15;
	localparam int BIT_STOP_IN_IDLE = 13;
	localparam int BIT_GATE_EN = 6;
	localparam int BIT_PRESCALE_HI = 5;
	localparam int BIT_PRESCALE_LO = 4;
	localparam int BIT_PAIR_MODE = 3;
	localparam int BIT_CLOCK_SRC = 1;
	localparam logic [15:0] EVEN_CTRL_MASK = 16'ha07a;
	localparam logic [15:0] ODD_CTRL_MASK = 16'ha072;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hffff;

	// status bit positions
	localparam int IRQ_EVEN = 0;
	localparam int IRQ_ODD = 1;

	// prescale ratios in cycles minus one
	localparam logic [7:0] DIV_1 = 8'h00;
	localparam logic [7:0] DIV_8 = 8'h07;
	localparam logic [7:0] DIV_64 = 8'h3f;
	localparam logic [7:0] DIV_256 = 8'hff;

	// decoded control fields of one timer
	typedef struct packed {
		logic on;
		logic stopIdle;
		logic gateEn;
		logic [1:0] prescaleSel;
		logic pairMode;
		logic clockSourceSel;
	} ctrl_s;

	// per-timer run inputs and outputs
	typedef struct packed {
		logic extClock;
		logic gate;
	} timer_in_s;

	typedef struct packed {
		logic evenMatch;
		logic oddMatch;
		logic adcTrigger;
	} timer_ev_s;

	// decode a control register image into its fields
	function automatic ctrl_s decode_ctrl(input logic [15:0] r);
		ctrl_s c;
		c.on = r[BIT_TIMER_ON];
		c.stopIdle = r[BIT_STOP_IN_IDLE];
		c.gateEn = r[BIT_GATE_EN];
		c.prescaleSel = r[BIT_PRESCALE_HI:BIT_PRESCALE_LO];
		c.pairMode = r[BIT_PAIR_MODE];
		c.clockSourceSel = r[BIT_CLOCK_SRC];
		return c;
	endfunction : decode_ctrl

	// prescale code to terminal count
	function automatic logic [7:0] prescale_limit(input logic [1:0] sel);
		case (sel)
			2'h0: return DIV_1;
			2'h1: return DIV_8;
			2'h2: return DIV_64;
			default: return DIV_256;
		endcase
	endfunction : prescale_limit

endpackage : paired_timer_pkg

/* src/timer_count_word.sv */
// one 16-bit count word with period compare and carry-in enable
`timescale 1ns/10ps
`default_nettype none
module timer_count_word
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic inc,
	input wire logic clear,
	input wire logic load,
	input wire logic [15:0] loadValue,
	input wire logic [15:0] period,
	// state
	output logic [15:0] count,
	output logic atPeriod
);
	import paired_timer_pkg::*;

	typedef struct packed {
		logic [15:0] count;
	} state_s;

	state_s q;
	state_s next_q;

	// next count: load wins, then clear, then increment
	always_comb
	begin
		next_q = q;
		if (load)
			next_q.count = loadValue;
		else if (clear)
			next_q.count = COUNT_RESET;
		else if (inc)
			next_q.count = q.count + 16'h0001;
	end

	// state register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q <= '0;
		else
			q <= next_q;
	end

	assign count = q.count;
	assign atPeriod = (q.count == period);

endmodule : timer_count_word
`default_nettype wire

/* src/timer_tick_gen.sv */
// one timer's clock select, edge detect, gating, idle stop and prescaler
`timescale 1ns/10ps
`default_nettype none
module timer_tick_gen
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration
	input wire paired_timer_pkg::ctrl_s ctrl,
	input wire logic ctrlWrite,
	input wire logic idle,
	// timer inputs
	input wire paired_timer_pkg::timer_in_s pins,
	// counting enable
	output logic tick
);
	import paired_timer_pkg::*;

	typedef struct packed {
		logic extPrev;
		logic [7:0] prescaleCount;
		logic tick;
	} state_s;

	state_s q;
	state_s next_q;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic source;
		logic run;
		source = 1'b0;
		run = 1'b0;
		next_q = q;
		next_q.extPrev = pins.extClock;
		next_q.tick = 1'b0;
		// rising edge of external pin, or every internal clock cycle with gating off or the gate pin high
		if (ctrl.clockSourceSel)
			source = pins.extClock & ~q.extPrev;
		else
			source = ~ctrl.gateEn | pins.gate;
		run = ctrl.on & ~(ctrl.stopIdle & idle);
		if (ctrlWrite)
			next_q.prescaleCount = 8'h00;
		else if (run && source)
		begin
			if (q.prescaleCount >= prescale_limit(ctrl.prescaleSel))
			begin
				next_q.prescaleCount = 8'h00;
				next_q.tick = 1'b1;
			end
			else
				next_q.prescaleCount = q.prescaleCount + 8'h01;
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q <= '0;
		else
			q <= next_q;
	end

	assign tick = q.tick;

endmodule : timer_tick_gen
`default_nettype wire
